// ===== pfsa_pkg.sv
package pfsa_pkg;
  // ---------------------------------------------------------------
  // register map, byte addresses on the wishbone slave
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_LOW_OFS = 5'h00;
  localparam logic [4:0] ADDR_HIGH_OFS = 5'h04;
  localparam logic [4:0] DATA_LOW_OFS = 5'h08;
  localparam logic [4:0] DATA_HIGH_OFS = 5'h0C;
  localparam logic [4:0] CTRL_OFS = 5'h10;
  localparam logic [4:0] KEY_OFS = 5'h14;
  localparam logic [4:0] STAT_OFS = 5'h18;

  // ---------------------------------------------------------------
  // fields of flash_ctrl_reg
  // ---------------------------------------------------------------
  localparam int CTRL_RD_BIT = 0;
  localparam int CTRL_WR_BIT = 1;
  localparam int CTRL_WRITE_PERMIT_BIT_BIT = 2;
  localparam int CTRL_ABORT_BIT = 3;
  localparam int CTRL_LWLO_BIT = 4;
  localparam int CTRL_FREE_BIT = 5;
  localparam int CTRL_CONFIG_SPACE_SELECT_BIT = 6;

  // ---------------------------------------------------------------
  // geometry and keys
  // ---------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int WORD_W = 14;
  localparam int ROW_W = 4;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [13:0] LATCH_BLANK = 14'h3FFF;
  localparam logic [1:0] FORCED_NOPS = 2'h2;
  localparam logic [1:0] READ_SLOT = 2'h2;

  // ---------------------------------------------------------------
  // timing: programming time in microseconds, clock in MHz
  // ---------------------------------------------------------------
  localparam int PROG_TIME_US = 2000;
  localparam int CLK_MHZ = 20;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

  typedef enum logic [4:0] {
    PF_IDLE = 5'h01,
    PF_READ = 5'h02,
    PF_NOPS = 5'h04,
    PF_PROG = 5'h08,
    PF_DONE = 5'h10
  } pf_state_t;
endpackage

// ===== pfsa_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// program flash array model with registered read port
// ---------------------------------------------------------------
module pfsa_mem #(
  parameter int AW = 9,
  parameter int DW = 14
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // single write port, erase is done as a write of blank words
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // read data always leaves from a register
  always_ff @(posedge clk_i)
  begin
    if (re_i)
    begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule
`default_nettype wire

// ===== pfsa_ctrl.sv
// Notes on behaviour
// RULE1: data pair holds one 14-bit word
// RULE2: address pair holds 9-bit word address
// RULE3: software writes address high then low parts
// RULE4: internal timer times every write and erase
// RULE5: code guard blocks programmer, not self-access
// RULE6: only programmer bulk erase releases guard; here any reset also reloads it from the config bit
// RULE7: self-write guard region refuses core writes
// RULE8: read and write triggers are set-only
// RULE9: writes need permit bit, cleared at power-up
// RULE10: reset during write sets abort flag
// RULE11: unlock key register reads as zero
// RULE12: latch load or program needs unlock key
// RULE13: rows of 16 words, erase unit
// RULE14: hidden 14-bit latches filled via data pair
// RULE15: software loads address, clears config_space_select, sets read
// RULE16: second cycle after read trigger is used
// RULE17: fetched word appears next cycle
// RULE18: data pair holds last read until rewritten
// RULE19: software places nops after read trigger
// RULE20: key 55h then AAh then write trigger
// RULE21: write trigger forces two nop slots
// RULE22: row operations stall core about 2 ms
// RULE23: unused address bits ignored, read zero
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module pfsa_ctrl
  import pfsa_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES,
  parameter int AW = ADDR_W,
  parameter int DW = WORD_W,
  parameter int RW = ROW_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // configuration word inputs and programmer port
  input wire logic code_guard_bit_i,
  input wire logic [1:0] self_write_guard_field_i,
  input wire logic prog_rd_i,
  input wire logic prog_bulk_erase_i,
  output logic prog_rd_block_o,
  output logic [DW-1:0] prog_rdata_o,
  // core pipeline control
  output logic core_nop_o,
  output logic core_stall_o
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [AW-1:0] addr_q;
  logic [DW-1:0] data_q;
  logic rd_q, wr_q, write_permit_bit_q, abort_q, lwlo_q, free_q, config_space_select_q;
  logic [1:0] key_q;
  logic guard_q;
  logic [DW-1:0] latch_q [0:(1<<RW)-1];
  pf_state_t state_q;
  logic [1:0] slot_q;
  logic [RW:0] row_idx_q;
  logic [$clog2(PROG_CYC+1)-1:0] tmr_q;
  logic op_erase_q, op_write_q;
  logic [2:0] prd_sync_q, bulk_sync_q;
  logic prd_live_q, bulk_live_q;

  logic acc, wr_acc, rd_acc, ack_pulse;
  logic mem_we, mem_re;
  logic [AW-1:0] mem_waddr, mem_raddr;
  logic [DW-1:0] mem_wdata, mem_rdata;
  logic row_guarded, wr_start;

  assign acc = cyc_i && stb_i && !ack_o;
  assign wr_acc = acc && we_i && sel_i[0];
  assign rd_acc = acc && !we_i;
  assign ack_pulse = acc;

  // ---------------------------------------------------------------
  // wishbone answer, one wait state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= ack_pulse;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      if (rd_acc)
      begin
        unique case (adr_i)
          ADDR_LOW_OFS: dat_o[7:0] <= addr_q[7:0];
          ADDR_HIGH_OFS: dat_o[AW-9:0] <= addr_q[AW-1:8]; // see RULE23
          DATA_LOW_OFS: dat_o[7:0] <= data_q[7:0];
          DATA_HIGH_OFS: dat_o[DW-9:0] <= data_q[DW-1:8];
          CTRL_OFS: dat_o[6:0] <= {config_space_select_q, free_q, lwlo_q, abort_q, write_permit_bit_q, wr_q, rd_q};
          KEY_OFS: dat_o <= 32'h0000_0000; // see RULE11
          STAT_OFS: dat_o[1:0] <= {core_stall_o, guard_q};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // address pair, extra bits dropped
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_q <= '0;
    end
    else if (wr_acc && adr_i == ADDR_LOW_OFS)
    begin
      addr_q[7:0] <= dat_i[7:0]; // see RULE2 RULE3
    end
    else if (wr_acc && adr_i == ADDR_HIGH_OFS)
    begin
      addr_q[AW-1:8] <= dat_i[AW-9:0]; // see RULE23
    end
  end

  // ---------------------------------------------------------------
  // data pair: last read kept until software or next read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_q <= '0;
    end
    else if (state_q == PF_DONE && rd_q)
    begin
      data_q <= mem_rdata; // see RULE17 RULE18
    end
    else if (wr_acc && adr_i == DATA_LOW_OFS)
    begin
      data_q[7:0] <= dat_i[7:0]; // see RULE1
    end
    else if (wr_acc && adr_i == DATA_HIGH_OFS)
    begin
      data_q[DW-1:8] <= dat_i[DW-9:0];
    end
  end

  // ---------------------------------------------------------------
  // unlock key tracker, any other bus write breaks the sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      key_q <= 2'h0;
    end
    else if (wr_acc)
    begin
      if (adr_i == KEY_OFS && dat_i[7:0] == KEY_FIRST)
      begin
        key_q <= 2'h1; // see RULE20
      end
      else if (adr_i == KEY_OFS && dat_i[7:0] == KEY_SECOND && key_q == 2'h1)
      begin
        key_q <= 2'h2;
      end
      else
      begin
        key_q <= 2'h0; // a trigger write also consumes the key
      end
    end
  end

  // write trigger only honoured straight after a full key, permit set
  assign wr_start = wr_acc && adr_i == CTRL_OFS && dat_i[CTRL_WR_BIT] && !wr_q && !rd_q
                    && key_q == 2'h2 && write_permit_bit_q && state_q == PF_IDLE; // see RULE9 RULE12

  // ---------------------------------------------------------------
  // control register; triggers are set-only, cleared by hardware
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      lwlo_q <= 1'b0;
      free_q <= 1'b0;
      config_space_select_q <= 1'b0;
    end
    else
    begin
      if (state_q == PF_DONE)
      begin
        rd_q <= 1'b0; // see RULE8
        wr_q <= 1'b0;
      end
      else if (wr_acc && adr_i == CTRL_OFS && state_q == PF_IDLE)
      begin
        if (dat_i[CTRL_RD_BIT] && !config_space_select_q && !dat_i[CTRL_CONFIG_SPACE_SELECT_BIT])
        begin
          rd_q <= 1'b1; // see RULE8 RULE15
        end
        if (wr_start)
        begin
          wr_q <= 1'b1;
        end
      end
      if (wr_acc && adr_i == CTRL_OFS && state_q == PF_IDLE)
      begin
        lwlo_q <= dat_i[CTRL_LWLO_BIT];
        free_q <= dat_i[CTRL_FREE_BIT];
        config_space_select_q <= dat_i[CTRL_CONFIG_SPACE_SELECT_BIT];
      end
    end
  end

  // permit bit cleared at power-up or by a control write, kept over other resets
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      write_permit_bit_q <= 1'b0; // see RULE9
    end
    else if (wr_acc && adr_i == CTRL_OFS)
    begin
      write_permit_bit_q <= dat_i[CTRL_WRITE_PERMIT_BIT_BIT];
    end
  end

  // abort flag survives ordinary reset so software can inspect it
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      abort_q <= 1'b0;
    end
    else if (rst_i && (state_q == PF_PROG || state_q == PF_NOPS) && wr_q)
    begin
      abort_q <= 1'b1; // see RULE10
    end
    else if (wr_acc && adr_i == CTRL_OFS && !dat_i[CTRL_ABORT_BIT])
    begin
      abort_q <= 1'b0;
    end
  end

  // programmer pins live in another clock domain; three stages each
  always_ff @(posedge clk_i)
  begin
    prd_sync_q <= {prd_sync_q[1:0], prog_rd_i};
    bulk_sync_q <= {bulk_sync_q[1:0], prog_bulk_erase_i};
  end

  // a change counts only once the last two stages agree, so a glitch never lands
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prd_live_q <= 1'b0;
      bulk_live_q <= 1'b0;
    end
    else
    begin
      if (prd_sync_q[1] == prd_sync_q[2])
      begin
        prd_live_q <= prd_sync_q[2];
      end
      if (bulk_sync_q[1] == bulk_sync_q[2])
      begin
        bulk_live_q <= bulk_sync_q[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // code guard: latched from config at reset, released by bulk erase or by a reset with the config bit set
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (bulk_live_q)
    begin
      guard_q <= 1'b0; // see RULE6
    end
    else if (rst_i)
    begin
      guard_q <= !code_guard_bit_i;
    end
  end

  // programmer reads blocked while guarded, core unaffected
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prog_rd_block_o <= 1'b0;
      prog_rdata_o <= '0;
    end
    else
    begin
      prog_rd_block_o <= guard_q; // see RULE5
      prog_rdata_o <= (prd_live_q && !guard_q) ? mem_rdata : '0;
    end
  end

  // self-write guard: 01 upper quarter free, 10 lower half, 00 all
  always_comb
  begin
    unique case (self_write_guard_field_i)
      2'h0: row_guarded = 1'b1; // see RULE7
      2'h1: row_guarded = (addr_q[AW-1:AW-2] != 2'h3);
      2'h2: row_guarded = !addr_q[AW-1];
      default: row_guarded = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer: read slot, forced nops, timed row operation
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= PF_IDLE;
      slot_q <= 2'h0;
      tmr_q <= '0;
      op_erase_q <= 1'b0;
      op_write_q <= 1'b0;
      row_idx_q <= '0;
    end
    else
    begin
      unique case (state_q)
        PF_IDLE:
        begin
          slot_q <= 2'h1;
          row_idx_q <= '0;
          if (wr_acc && adr_i == CTRL_OFS && dat_i[CTRL_RD_BIT] && !dat_i[CTRL_CONFIG_SPACE_SELECT_BIT])
          begin
            state_q <= PF_READ;
          end
          else if (wr_start)
          begin
            state_q <= PF_NOPS;
            op_erase_q <= free_q && !row_guarded;
            op_write_q <= !free_q && !lwlo_q && !row_guarded;
          end
        end
        PF_READ:
        begin
          slot_q <= slot_q + 2'h1;
          if (slot_q == READ_SLOT)
          begin
            state_q <= PF_DONE; // see RULE16
          end
        end
        PF_NOPS:
        begin
          slot_q <= slot_q + 2'h1;
          tmr_q <= '0;
          if (slot_q == FORCED_NOPS)
          begin
            state_q <= (op_erase_q || op_write_q) ? PF_PROG : PF_DONE; // see RULE21
          end
        end
        PF_PROG:
        begin
          tmr_q <= tmr_q + 1'b1;
          if (row_idx_q != (RW+1)'(1 << RW))
          begin
            row_idx_q <= row_idx_q + 1'b1;
          end
          if (tmr_q == ($bits(tmr_q))'(PROG_CYC - 1))
          begin
            state_q <= PF_DONE; // see RULE4 RULE22
          end
        end
        PF_DONE:
        begin
          state_q <= PF_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // write latches: loaded only after unlock, blanked after program
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < (1 << RW); gi++)
    begin : g_latch
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          latch_q[gi] <= LATCH_BLANK;
        end
        else if (state_q == PF_PROG && tmr_q == ($bits(tmr_q))'(PROG_CYC - 1) && op_write_q)
        begin
          latch_q[gi] <= LATCH_BLANK;
        end
        else if (wr_start && !free_q && addr_q[RW-1:0] == RW'(gi))
        begin
          latch_q[gi] <= data_q; // see RULE12 RULE14
        end
      end
    end
  endgenerate

  // row sweep into the array, one word per cycle at start of the timed window
  assign mem_we = state_q == PF_PROG && !row_idx_q[RW] && (op_erase_q || op_write_q);
  assign mem_waddr = {addr_q[AW-1:RW], row_idx_q[RW-1:0]}; // see RULE13
  assign mem_wdata = op_erase_q ? LATCH_BLANK : latch_q[row_idx_q[RW-1:0]];
  assign mem_re = (state_q == PF_READ && slot_q == READ_SLOT) || prd_live_q;
  assign mem_raddr = addr_q;

  pfsa_mem #(
    .AW(AW),
    .DW(DW)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .re_i(mem_re),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // ---------------------------------------------------------------
  // core pipeline control
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_nop_o <= 1'b0;
      core_stall_o <= 1'b0;
    end
    else
    begin
      core_nop_o <= (state_q == PF_NOPS) || (state_q == PF_READ && slot_q == 2'h1);
      core_stall_o <= (state_q == PF_PROG); // see RULE22
    end
  end
endmodule
`default_nettype wire

// ===== pfsa_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// bus and core-side checker
// ---------------------------------------------------------------
module pfsa_chk
  import pfsa_pkg::*;
#(
  parameter int PROG_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic prog_rd_block_o,
  input wire logic [13:0] prog_rdata_o,
  input wire logic core_nop_o,
  input wire logic core_stall_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd_ack;
  logic wr_trig;
  logic [31:0] stl_q;
  assign rd_ack = ack_o && !we_i;
  // write trigger taken; a read trigger forces only one slot, so it is kept out
  assign wr_trig = cyc_i && stb_i && we_i && !ack_o && adr_i == CTRL_OFS
                   && dat_i[CTRL_WR_BIT] && !dat_i[CTRL_RD_BIT];
  // stall length; a timer that never expires would hang the core
  always_ff @(posedge clk_i)
    if (rst_i || !core_stall_o)
      stl_q <= '0;
    else
      stl_q <= stl_q + 32'h1;
  a_ack_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one wait state");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_err_low: assert property (!err_o)
    else $error("error response seen");
  a_key_zero: assert property (rd_ack && adr_i == KEY_OFS |-> dat_o == '0)
    else $error("key register read not zero");
  a_addr_hi: assert property (rd_ack && adr_i == ADDR_HIGH_OFS |-> dat_o[31:1] == '0)
    else $error("unused address bits not zero");
  a_data_hi: assert property (rd_ack && adr_i == DATA_HIGH_OFS |-> dat_o[31:6] == '0)
    else $error("data pair wider than a word");
  a_guard_data: assert property (prog_rd_block_o |-> prog_rdata_o == '0)
    else $error("guarded word leaked to programmer");
  a_nop_two: assert property ($rose(core_nop_o) && $past(wr_trig, 2)
    |-> core_nop_o ##1 core_nop_o)
    else $error("fewer than two forced slots");
  a_nop_first: assert property ($rose(core_stall_o) |-> $past(core_nop_o))
    else $error("stall without forced slots first");
  a_stall_max: assert property (stl_q < PROG_CYC + 8)
    else $error("stall outlasts programming time");
  c_stall: cover property ($rose(core_stall_o));
  c_key_rd: cover property (rd_ack && adr_i == KEY_OFS);
  c_guard: cover property (prog_rd_block_o);
endmodule
bind pfsa_ctrl pfsa_chk #(.PROG_CYC(PROG_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .prog_rd_block_o(prog_rd_block_o),
  .prog_rdata_o(prog_rdata_o), .core_nop_o(core_nop_o), .core_stall_o(core_stall_o));
`default_nettype wire

// ===== pfsa_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// self-checking bench
// ---------------------------------------------------------------
module pfsa_ctrl_tb_top;
  import pfsa_pkg::*;
  localparam int PC = 20;
  logic clk_i;
  logic rst_i;
  logic por_i;
  logic cyc_i;
  logic stb_i;
  logic we_i;
  logic cg_i;
  logic pr_i;
  logic be_i;
  logic [1:0] wg_i;
  logic [3:0] sel_i;
  logic [3:0] sel_use = 4'hF;
  logic [4:0] adr_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic [13:0] prd_o;
  logic ack_o;
  logic err_o;
  logic blk_o;
  logic nop_o;
  logic stl_o;
  int err_count;
  int comparisons;
  int stall_cnt = 0;
  int nop_cnt = 0;
  pfsa_ctrl #(.PROG_CYC(PC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .code_guard_bit_i(cg_i),
    .self_write_guard_field_i(wg_i), .prog_rd_i(pr_i), .prog_bulk_erase_i(be_i),
    .prog_rd_block_o(blk_o), .prog_rdata_o(prd_o), .core_nop_o(nop_o),
    .core_stall_o(stl_o));
  // free-running 20 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // stalled and forced-nop cycles over the whole run; tasks take differences
  always @(posedge clk_i)
  begin
    if (stl_o === 1'b1)
      stall_cnt <= stall_cnt + 1;
    if (nop_o === 1'b1)
      nop_cnt <= nop_cnt + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= sel_use;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    check({31'h0, ack_o}, 32'h1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr_rd(input logic [4:0] a, input logic [31:0] w, input logic [31:0] exp);
    wb(1'b1, a, w);
    wb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic do_rst();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic rd_word(input logic [8:0] a, input logic [13:0] exp);
    int n;
    int nops;
    wb(1'b1, ADDR_LOW_OFS, {24'h0, a[7:0]});
    wb(1'b1, ADDR_HIGH_OFS, {31'h0, a[8]});
    nops = nop_cnt;
    wb(1'b1, CTRL_OFS, 32'h1);
    n = 0;
    do
    begin
      wb(1'b0, CTRL_OFS, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 20);
    check({31'h0, rd[0]}, 32'h0);
    check(nop_cnt - nops, 32'h1);
    wb(1'b0, DATA_LOW_OFS, 32'h0);
    check(rd, {24'h0, exp[7:0]});
    wb(1'b0, DATA_HIGH_OFS, 32'h0);
    check(rd, {26'h0, exp[13:8]});
  endtask
  // key and trigger; brk resets the block in mid-stall
  task automatic prog(input logic [8:0] a, input logic [13:0] d, input logic [31:0] ctl,
    input logic key, input logic brk, input logic good);
    int n;
    int base;
    wb(1'b1, ADDR_LOW_OFS, {24'h0, a[7:0]});
    wb(1'b1, ADDR_HIGH_OFS, {31'h0, a[8]});
    wb(1'b1, DATA_LOW_OFS, {24'h0, d[7:0]});
    wb(1'b1, DATA_HIGH_OFS, {26'h0, d[13:8]});
    wb(1'b1, CTRL_OFS, ctl);
    if (key)
    begin
      wb(1'b1, KEY_OFS, {24'h0, KEY_FIRST});
      wb(1'b1, KEY_OFS, {24'h0, KEY_SECOND});
    end
    base = stall_cnt;
    wb(1'b1, CTRL_OFS, ctl | 32'h2);
    n = 0;
    if (brk)
    begin
      while (stl_o !== 1'b1 && n < 60)
      begin
        @(posedge clk_i);
        n++;
      end
      do_rst();
      wr_rd(STAT_OFS, 32'h0, 32'h0);
      wb(1'b0, CTRL_OFS, 32'h0);
      check({31'h0, rd[3]}, 32'h1);
      wb(1'b1, CTRL_OFS, 32'h0);
      wb(1'b0, CTRL_OFS, 32'h0);
      check({31'h0, rd[3]}, 32'h0);
    end
    else
    begin
      do
      begin
        wb(1'b0, CTRL_OFS, 32'h0);
        n++;
      end
      while (rd[1] !== 1'b0 && n < 60);
      check({31'h0, rd[1]}, 32'h0);
      check({31'h0, good ? stall_cnt - base >= PC : stall_cnt == base}, 32'h1);
    end
  endtask
  task automatic t_regs();
    wb(1'b0, CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    wr_rd(KEY_OFS, {24'h0, KEY_FIRST}, 32'h0);
    wr_rd(ADDR_HIGH_OFS, 32'hFF, 32'h1);
    wr_rd(DATA_HIGH_OFS, 32'hFF, 32'h3F);
    wr_rd(DATA_LOW_OFS, 32'hA5, 32'hA5);
    sel_use = 4'h0;
    wb(1'b1, DATA_LOW_OFS, 32'h3C);
    sel_use = 4'hF;
    wb(1'b0, DATA_LOW_OFS, 32'h0);
    check(rd, 32'hA5);
    wr_rd(5'h1C, 32'h5A, 32'h0);
  endtask
  task automatic t_write();
    wg_i <= 2'h3;
    prog(9'h3, 14'h0, 32'h24, 1'b1, 1'b0, 1'b1);
    rd_word(9'hF, LATCH_BLANK);
    prog(9'h4, 14'h0123, 32'h14, 1'b1, 1'b0, 1'b0);
    prog(9'h3, 14'h2A5C, 32'h4, 1'b1, 1'b0, 1'b1);
    rd_word(9'h3, 14'h2A5C);
    rd_word(9'h4, 14'h0123);
    rd_word(9'h6, LATCH_BLANK);
  endtask
  // no key, no permit, then each guard field that covers the bottom
  task automatic t_refuse();
    for (int i = 0; i < 5; i++)
    begin
      wg_i <= (i < 2) ? 2'h3 : 2'(i - 2);
      prog(9'h3, 14'h1111, (i == 1) ? 32'h0 : 32'h4, i != 0, 1'b0, 1'b0);
      rd_word(9'h3, 14'h2A5C);
    end
    wg_i <= 2'h3;
  endtask
  task automatic t_guard();
    cg_i <= 1'b0;
    pr_i <= 1'b1;
    do_rst();
    rd_word(9'h3, 14'h2A5C);
    check({31'h0, blk_o}, 32'h1);
    check({18'h0, prd_o}, 32'h0);
    be_i <= 1'b1;
    cg_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    be_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check({31'h0, blk_o}, 32'h0);
    check({18'h0, prd_o}, {18'h0, 14'h2A5C});
  endtask
  // inputs at time zero, then power-up reset for 16 cycles
  initial
  begin
    err_count = 0;
    comparisons = 0;
    sel_i = 4'h0;
    {rst_i, por_i, cg_i} = 3'h7;
    {cyc_i, stb_i, we_i, pr_i, be_i} = 5'h0;
    wg_i = 2'h3;
    adr_i = 5'h00;
    dat_i = 32'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    t_regs();
    t_write();
    t_refuse();
    t_guard();
    prog(9'h8, 14'h0AAA, 32'h4, 1'b1, 1'b1, 1'b1);
    finish_test();
  end
  // hang guard, far beyond the several hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
